//--- rtl/lock_loss_nvm_map.vh
// offsets, field positions, reset values and timing for the lock-loss and nv control bank
// What this block does
// RULE1 - per-loop slow lock-loss enable, 0x9A bits 1:0
// RULE2 - 4-bit set threshold per loop at 0x9E
// RULE3 - 4-bit clear threshold per loop at 0xA0
// RULE4 - threshold codes decode to ppm limits; 11-15 reserved
// RULE5 - 4-bit fast clear threshold per loop, 0x98
// RULE6 - 4-bit slow detection window per loop, 0x9B
// RULE7 - 2-bit slow validation window per loop, 0x9D
// RULE8 - per-loop clear-delay enable, 0xA2 bits 1:0
// RULE9 - enabled delay holds lock-loss after clock returns
// RULE10 - 29-bit clear-delay counts, little-endian byte spread
// RULE11 - active bank reads 0x03, 0x0F, 0x3F
// RULE12 - software never burns once status reads 0x3F
// RULE13 - writing 0xC7 to 0xE3 starts a burn
// RULE14 - writing 1 to 0xE4 bit0 starts copy
// RULE15 - acquire-extend enables at 0xE5 bits 4, 5
// RULE16 - 29-bit acquire-extend duration loop a, 0xE6-0xE9
// RULE17 - software polls ready byte after burn before access
// RULE18 - assert above set, clear below clear after delay
// RULE19 - copy bit self-clears when copy completes
`ifndef LOCK_LOSS_NVM_MAP_VH
`define LOCK_LOSS_NVM_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define OFS_FAST_CLR_THR 8'h98
`define OFS_SLOW_EN 8'h9A
`define OFS_SLOW_DETWIN 8'h9B
`define OFS_SLOW_VALWIN 8'h9D
`define OFS_SET_THR 8'h9E
`define OFS_CLR_THR 8'hA0
`define OFS_CLR_DLY_EN 8'hA2
`define OFS_CLR_DLY_A0 8'hA4
`define OFS_CLR_DLY_A3 8'hA7
`define OFS_CLR_DLY_B0 8'hA9
`define OFS_CLR_DLY_B3 8'hAC
`define OFS_ACTIVE_BANK 8'hE2
`define OFS_BURN_TRIG 8'hE3
`define OFS_COPY_TRIG 8'hE4
`define OFS_EXT_EN 8'hE5
`define OFS_EXT_DUR_A0 8'hE6
`define OFS_EXT_DUR_A3 8'hE9

// ****************************************
// field positions and codes
// ****************************************
`define EXT_EN_A_BIT 4
`define EXT_EN_B_BIT 5
`define COPY_BIT 0
`define BURN_KEY 8'hC7
`define BANK_NONE 8'h03
`define BANK_ONE 8'h0F
`define BANK_TWO 8'h3F
`define BANK_MAX 2'h2

// ****************************************
// reset values
// ****************************************
`define RST_BYTE 8'h00
`define RST_WIDE 29'h0000000

// ****************************************
// timing: delay count is in units of 2**shift clocks
// ****************************************
`define DLY_SHIFT 8

// threshold limits in units of 0.1 ppm
`define LIM_0 17'h00001
`define LIM_1 17'h00003
`define LIM_2 17'h0000A
`define LIM_3 17'h0001E
`define LIM_4 17'h00064
`define LIM_5 17'h0012C
`define LIM_6 17'h003E8
`define LIM_7 17'h00BB8
`define LIM_8 17'h02710
`define LIM_9 17'h07530
`define LIM_10 17'h186A0
`define LIM_RSVD 17'h1FFFF

`endif

//--- rtl/lock_loss_monitor.v
// one loop's slow lock-loss detector with clear-delay timer
`timescale 1ns/100ps
`include "lock_loss_nvm_map.vh"
module lock_loss_monitor (
    input wire clk,
    input wire reset,
    input wire enable,
    input wire [3:0] set_code,
    input wire [3:0] clear_code,
    input wire delay_enable,
    input wire [28:0] delay_count,
    input wire [16:0] freq_error,
    output reg lock_loss_q
);
    // code to limit; reserved codes map to the top limit: they never trip, and clear for any error below it
    function [16:0] limit_of;
        input [3:0] code;
        begin
            case (code)
                4'h0: limit_of = `LIM_0;
                4'h1: limit_of = `LIM_1;
                4'h2: limit_of = `LIM_2;
                4'h3: limit_of = `LIM_3;
                4'h4: limit_of = `LIM_4;
                4'h5: limit_of = `LIM_5;
                4'h6: limit_of = `LIM_6;
                4'h7: limit_of = `LIM_7;
                4'h8: limit_of = `LIM_8;
                4'h9: limit_of = `LIM_9;
                4'hA: limit_of = `LIM_10;
                default: limit_of = `LIM_RSVD;
            endcase
        end
    endfunction

    wire [16:0] set_limit = limit_of(set_code); // RULE4
    wire [16:0] clear_limit = limit_of(clear_code); // RULE4
    wire [36:0] delay_load = {delay_count, 8'h00};
    reg [36:0] wait_q;

    // assert over set limit; clear only under clear limit, once the timer ran out if the delay is enabled
    always @(posedge clk) begin
        if (reset || !enable) begin // RULE1
            lock_loss_q <= 1'b0;
            wait_q <= 37'h0000000000;
        end else if (freq_error > set_limit) begin // RULE18
            lock_loss_q <= 1'b1;
            wait_q <= delay_load;
        end else if (lock_loss_q && freq_error < clear_limit) begin
            if (!delay_enable || wait_q == 37'h0000000000) begin // RULE9
                lock_loss_q <= 1'b0; // RULE18
            end else begin
                wait_q <= wait_q - 37'h0000000001;
            end
        end else begin
            // error drifted back up: the clock is not yet stable, restart the wait
            wait_q <= delay_load; // RULE9
        end
    end
endmodule

//--- rtl/lock_loss_and_nvm_control_regs.v
// lock-loss configuration, nonvolatile bank control and acquire-extend register bank
`timescale 1ns/100ps
`include "lock_loss_nvm_map.vh"
module lock_loss_and_nvm_control_regs (
    input wire clk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    input wire [16:0] freq_error_a,
    input wire [16:0] freq_error_b,
    output wire lock_loss_a,
    output wire lock_loss_b,
    output reg [3:0] fast_clear_threshold_a,
    output reg [3:0] fast_clear_threshold_b,
    output reg [3:0] slow_detect_window_a,
    output reg [3:0] slow_detect_window_b,
    output reg [1:0] slow_valid_window_a,
    output reg [1:0] slow_valid_window_b,
    output reg acquire_extend_enable_a,
    output reg acquire_extend_enable_b,
    output reg [28:0] acquire_extend_duration_a,
    input wire [1:0] nv_banks_used,
    output reg nv_burn_start,
    input wire nv_burn_done,
    output reg nv_burn_busy,
    output reg nv_copy_start,
    input wire nv_copy_done
);

    // ****************************************
    // storage
    // ****************************************
    reg [1:0] slow_detect_enable_q;
    reg [3:0] set_threshold_a_q;
    reg [3:0] set_threshold_b_q;
    reg [3:0] clear_threshold_a_q;
    reg [3:0] clear_threshold_b_q;
    reg [1:0] clear_delay_enable_q;
    reg [28:0] clear_delay_count_a_q;
    reg [28:0] clear_delay_count_b_q;
    reg [7:0] burn_trigger_q;
    reg copy_busy_q;
    reg [1:0] banks_used_q;
    reg banks_loaded_q;
    wire wr_burn;
    wire wr_copy;

    // one byte lane of a 29-bit field, top lane keeps only five bits
    function [28:0] put_byte;
        input [28:0] old;
        input [1:0] lane;
        input [7:0] data;
        begin
            put_byte = old;
            case (lane)
                2'h0: put_byte[7:0] = data;
                2'h1: put_byte[15:8] = data;
                2'h2: put_byte[23:16] = data;
                2'h3: put_byte[28:24] = data[4:0];
                default: put_byte = old;
            endcase
        end
    endfunction

    // read a byte lane of a 29-bit field, unused top bits zero
    function [7:0] get_byte;
        input [28:0] val;
        input [1:0] lane;
        begin
            case (lane)
                2'h0: get_byte = val[7:0];
                2'h1: get_byte = val[15:8];
                2'h2: get_byte = val[23:16];
                2'h3: get_byte = {3'h0, val[28:24]};
                default: get_byte = 8'h00;
            endcase
        end
    endfunction

    // lane index of a wide field from its base offset
    function [1:0] lane_of;
        input [7:0] addr;
        input [7:0] base;
        reg [7:0] diff;
        begin
            diff = addr - base;
            lane_of = diff[1:0];
        end
    endfunction

    wire in_dly_a = reg_addr >= `OFS_CLR_DLY_A0 && reg_addr <= `OFS_CLR_DLY_A3;
    wire in_dly_b = reg_addr >= `OFS_CLR_DLY_B0 && reg_addr <= `OFS_CLR_DLY_B3;
    wire in_ext_a = reg_addr >= `OFS_EXT_DUR_A0 && reg_addr <= `OFS_EXT_DUR_A3;

    // ****************************************
    // configuration writes
    // ****************************************
    // multi-byte fields take each byte at once: software should write them
    // while the loop is not relying on the value, there is no shadow copy
    always @(posedge clk) begin
        if (reset) begin
            fast_clear_threshold_a <= 4'h0;
            fast_clear_threshold_b <= 4'h0;
            slow_detect_enable_q <= 2'h0;
            slow_detect_window_a <= 4'h0;
            slow_detect_window_b <= 4'h0;
            slow_valid_window_a <= 2'h0;
            slow_valid_window_b <= 2'h0;
            set_threshold_a_q <= 4'h0;
            set_threshold_b_q <= 4'h0;
            clear_threshold_a_q <= 4'h0;
            clear_threshold_b_q <= 4'h0;
            clear_delay_enable_q <= 2'h0;
            clear_delay_count_a_q <= `RST_WIDE;
            clear_delay_count_b_q <= `RST_WIDE;
            acquire_extend_enable_a <= 1'b0;
            acquire_extend_enable_b <= 1'b0;
            acquire_extend_duration_a <= `RST_WIDE;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFS_FAST_CLR_THR: begin // RULE5
                    fast_clear_threshold_a <= reg_wdata[3:0];
                    fast_clear_threshold_b <= reg_wdata[7:4];
                end
                `OFS_SLOW_EN: begin
                    slow_detect_enable_q <= reg_wdata[1:0]; // RULE1
                end
                `OFS_SLOW_DETWIN: begin // RULE6
                    slow_detect_window_a <= reg_wdata[3:0];
                    slow_detect_window_b <= reg_wdata[7:4];
                end
                `OFS_SLOW_VALWIN: begin // RULE7
                    slow_valid_window_a <= reg_wdata[1:0];
                    slow_valid_window_b <= reg_wdata[3:2];
                end
                `OFS_SET_THR: begin // RULE2
                    set_threshold_a_q <= reg_wdata[3:0];
                    set_threshold_b_q <= reg_wdata[7:4];
                end
                `OFS_CLR_THR: begin // RULE3
                    clear_threshold_a_q <= reg_wdata[3:0];
                    clear_threshold_b_q <= reg_wdata[7:4];
                end
                `OFS_CLR_DLY_EN: begin
                    clear_delay_enable_q <= reg_wdata[1:0]; // RULE8
                end
                `OFS_EXT_EN: begin // RULE15
                    acquire_extend_enable_a <= reg_wdata[`EXT_EN_A_BIT];
                    acquire_extend_enable_b <= reg_wdata[`EXT_EN_B_BIT];
                end
                default: begin
                    // wide fields are decoded by range below
                    if (in_dly_a) begin // RULE10
                        clear_delay_count_a_q <= put_byte(clear_delay_count_a_q,
                            lane_of(reg_addr, `OFS_CLR_DLY_A0), reg_wdata);
                    end
                    if (in_dly_b) begin // RULE10
                        clear_delay_count_b_q <= put_byte(clear_delay_count_b_q,
                            lane_of(reg_addr, `OFS_CLR_DLY_B0), reg_wdata);
                    end
                    if (in_ext_a) begin // RULE16
                        acquire_extend_duration_a <= put_byte(acquire_extend_duration_a,
                            lane_of(reg_addr, `OFS_EXT_DUR_A0), reg_wdata);
                    end
                end
            endcase
        end
    end

    // ****************************************
    // nonvolatile bank control
    // ****************************************
    assign wr_burn = reg_wr && reg_addr == `OFS_BURN_TRIG;
    assign wr_copy = reg_wr && reg_addr == `OFS_COPY_TRIG && reg_wdata[`COPY_BIT];

    // burned-bank count is taken from the nv macro one cycle after reset release
    always @(posedge clk) begin
        if (reset) begin
            banks_loaded_q <= 1'b0;
            banks_used_q <= 2'h0;
        end else if (!banks_loaded_q) begin
            banks_loaded_q <= 1'b1;
            banks_used_q <= nv_banks_used;
        end else if (nv_burn_busy && nv_burn_done && banks_used_q < `BANK_MAX) begin
            banks_used_q <= banks_used_q + 2'h1;
        end
    end

    // burn key starts one burn; refused while busy or with no bank left
    always @(posedge clk) begin
        if (reset) begin
            burn_trigger_q <= `RST_BYTE;
            nv_burn_start <= 1'b0;
            nv_burn_busy <= 1'b0;
        end else begin
            nv_burn_start <= 1'b0;
            if (wr_burn) begin
                burn_trigger_q <= reg_wdata;
            end
            if (wr_burn && reg_wdata == `BURN_KEY && !nv_burn_busy && banks_loaded_q
                && banks_used_q < `BANK_MAX) begin // RULE13
                nv_burn_start <= 1'b1;
                nv_burn_busy <= 1'b1;
            end else if (nv_burn_done) begin
                nv_burn_busy <= 1'b0;
            end
        end
    end

    // copy bit: a new request in the done cycle wins and keeps it set
    always @(posedge clk) begin
        if (reset) begin
            copy_busy_q <= 1'b0;
            nv_copy_start <= 1'b0;
        end else begin
            nv_copy_start <= wr_copy && !copy_busy_q; // RULE14
            if (wr_copy) begin
                copy_busy_q <= 1'b1; // RULE14
            end else if (nv_copy_done) begin
                copy_busy_q <= 1'b0; // RULE19
            end
        end
    end

    // ****************************************
    // lock-loss detectors, one per loop
    // ****************************************
    wire [33:0] freq_error_all = {freq_error_b, freq_error_a};
    wire [7:0] set_all = {set_threshold_b_q, set_threshold_a_q};
    wire [7:0] clear_all = {clear_threshold_b_q, clear_threshold_a_q};
    wire [57:0] delay_all = {clear_delay_count_b_q, clear_delay_count_a_q};
    wire [1:0] lock_loss_all;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : loop_mon
            lock_loss_monitor mon (
                .clk(clk),
                .reset(reset),
                .enable(slow_detect_enable_q[g]),
                .set_code(set_all[g*4 +: 4]),
                .clear_code(clear_all[g*4 +: 4]),
                .delay_enable(clear_delay_enable_q[g]),
                .delay_count(delay_all[g*29 +: 29]),
                .freq_error(freq_error_all[g*17 +: 17]),
                .lock_loss_q(lock_loss_all[g])
            );
        end
    endgenerate

    assign lock_loss_a = lock_loss_all[0];
    assign lock_loss_b = lock_loss_all[1];

    // ****************************************
    // read path
    // ****************************************
    reg [7:0] rd_mux;
    reg [7:0] bank_code;

    // status code from burned-bank count
    always @* begin
        case (banks_used_q)
            2'h0: bank_code = `BANK_NONE; // RULE11
            2'h1: bank_code = `BANK_ONE; // RULE11
            default: bank_code = `BANK_TWO; // RULE11
        endcase
    end

    // unmapped offsets and reserved bits read as zero
    always @* begin
        rd_mux = 8'h00;
        case (reg_addr)
            `OFS_FAST_CLR_THR: rd_mux = {fast_clear_threshold_b, fast_clear_threshold_a};
            `OFS_SLOW_EN: rd_mux = {6'h00, slow_detect_enable_q};
            `OFS_SLOW_DETWIN: rd_mux = {slow_detect_window_b, slow_detect_window_a};
            `OFS_SLOW_VALWIN: rd_mux = {4'h0, slow_valid_window_b, slow_valid_window_a};
            `OFS_SET_THR: rd_mux = {set_threshold_b_q, set_threshold_a_q};
            `OFS_CLR_THR: rd_mux = {clear_threshold_b_q, clear_threshold_a_q};
            `OFS_CLR_DLY_EN: rd_mux = {6'h00, clear_delay_enable_q};
            `OFS_ACTIVE_BANK: rd_mux = bank_code;
            `OFS_BURN_TRIG: rd_mux = burn_trigger_q;
            `OFS_COPY_TRIG: rd_mux = {7'h00, copy_busy_q};
            `OFS_EXT_EN: rd_mux = {2'h0, acquire_extend_enable_b, acquire_extend_enable_a,
                4'h0};
            default: begin
                if (in_dly_a) begin
                    rd_mux = get_byte(clear_delay_count_a_q,
                        lane_of(reg_addr, `OFS_CLR_DLY_A0));
                end else if (in_dly_b) begin
                    rd_mux = get_byte(clear_delay_count_b_q,
                        lane_of(reg_addr, `OFS_CLR_DLY_B0));
                end else if (in_ext_a) begin
                    rd_mux = get_byte(acquire_extend_duration_a,
                        lane_of(reg_addr, `OFS_EXT_DUR_A0));
                end
            end
        endcase
    end

    // read data registered, valid one cycle after the strobe
    always @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

endmodule

//--- verif/lock_loss_regs_chk.sv
// port assertions for the lock-loss and nonvolatile control register bank
`timescale 1ns/100ps
module lock_loss_regs_chk (
    input wire clk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    input wire reg_rvalid,
    input wire [3:0] fast_clear_threshold_a,
    input wire [3:0] fast_clear_threshold_b,
    input wire [3:0] slow_detect_window_a,
    input wire [3:0] slow_detect_window_b,
    input wire [1:0] slow_valid_window_a,
    input wire [1:0] slow_valid_window_b,
    input wire acquire_extend_enable_a,
    input wire acquire_extend_enable_b,
    input wire [28:0] acquire_extend_duration_a,
    input wire nv_burn_start,
    input wire nv_burn_done,
    input wire nv_burn_busy,
    input wire nv_copy_start
);
    // ********
    // one clock, reset masks everything
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // burn steps: key write, then the finishing handshake
    sequence s_key;
        reg_wr && reg_addr == 8'hE3 && reg_wdata == 8'hC7;
    endsequence
    sequence s_done;
        nv_burn_busy && nv_burn_done;
    endsequence

    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read got no answer");
    a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without read");
    a_burn_cause: assert property (nv_burn_start |-> $past(reg_wr && reg_addr == 8'hE3 && reg_wdata == 8'hC7))
        else $error("burn start without key");
    a_burn_busy_key: assert property (s_key ##0 nv_burn_busy |=> !nv_burn_start)
        else $error("burn restarted while busy");
    a_burn_pulse: assert property (nv_burn_start |=> !nv_burn_start)
        else $error("burn start too long");
    a_busy_rise: assert property ($rose(nv_burn_busy) |-> nv_burn_start)
        else $error("busy without start");
    a_busy_hold: assert property (nv_burn_busy && !nv_burn_done |=> nv_burn_busy)
        else $error("busy dropped early");
    a_busy_drop: assert property (s_done |=> !nv_burn_busy)
        else $error("busy stuck after done");
    a_copy_cause: assert property (nv_copy_start |-> $past(reg_wr && reg_addr == 8'hE4 && reg_wdata[0]))
        else $error("copy start without request");
    a_fast_thr_store: assert property (reg_wr && reg_addr == 8'h98 |=>
        {fast_clear_threshold_b, fast_clear_threshold_a} == $past(reg_wdata))
        else $error("fast clear threshold not stored");
    a_detwin_store: assert property (reg_wr && reg_addr == 8'h9B |=>
        {slow_detect_window_b, slow_detect_window_a} == $past(reg_wdata))
        else $error("detect window not stored");
    a_valwin_store: assert property (reg_wr && reg_addr == 8'h9D |=>
        {slow_valid_window_b, slow_valid_window_a} == $past(reg_wdata[3:0]))
        else $error("valid window not stored");
    a_extend_enable: assert property (reg_wr && reg_addr == 8'hE5 |=>
        {acquire_extend_enable_b, acquire_extend_enable_a} == $past(reg_wdata[5:4]))
        else $error("extend enables not stored");
    a_extend_top: assert property (reg_wr && reg_addr == 8'hE9 |=>
        acquire_extend_duration_a[28:24] == $past(reg_wdata[4:0]))
        else $error("extend top byte not stored");
endmodule

bind lock_loss_and_nvm_control_regs lock_loss_regs_chk chk_u (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
    .fast_clear_threshold_a(fast_clear_threshold_a),
    .fast_clear_threshold_b(fast_clear_threshold_b),
    .slow_detect_window_a(slow_detect_window_a), .slow_detect_window_b(slow_detect_window_b),
    .slow_valid_window_a(slow_valid_window_a), .slow_valid_window_b(slow_valid_window_b),
    .acquire_extend_enable_a(acquire_extend_enable_a),
    .acquire_extend_enable_b(acquire_extend_enable_b),
    .acquire_extend_duration_a(acquire_extend_duration_a), .nv_burn_start(nv_burn_start),
    .nv_burn_done(nv_burn_done), .nv_burn_busy(nv_burn_busy), .nv_copy_start(nv_copy_start)
);

//--- verif/test_lock_loss_and_nvm_control_regs.sv
// self-checking bench for the lock-loss and nonvolatile control register bank
`timescale 1ns/100ps
module test_lock_loss_and_nvm_control_regs;
    reg clk, reset, reg_wr, reg_rd, nv_burn_done, nv_copy_done;
    reg [7:0] reg_addr, reg_wdata;
    reg [16:0] freq_error_a, freq_error_b;
    reg [1:0] nv_banks_used;
    wire [7:0] reg_rdata;
    wire reg_rvalid, lock_loss_a, lock_loss_b, nv_burn_start, nv_burn_busy, nv_copy_start;
    wire [28:0] acquire_extend_duration_a;
    integer n_mismatch = 0, compares = 0, cycles = 0, n_burn = 0, n_copy = 0, i, p;
    reg [23:0] rows [0:23];
    reg [16:0] lim [0:10];

    lock_loss_and_nvm_control_regs dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .freq_error_a(freq_error_a), .freq_error_b(freq_error_b),
        .lock_loss_a(lock_loss_a), .lock_loss_b(lock_loss_b), .fast_clear_threshold_a(),
        .fast_clear_threshold_b(), .slow_detect_window_a(), .slow_detect_window_b(),
        .slow_valid_window_a(), .slow_valid_window_b(), .acquire_extend_enable_a(),
        .acquire_extend_enable_b(), .acquire_extend_duration_a(acquire_extend_duration_a),
        .nv_banks_used(nv_banks_used), .nv_burn_start(nv_burn_start),
        .nv_burn_done(nv_burn_done), .nv_burn_busy(nv_burn_busy),
        .nv_copy_start(nv_copy_start), .nv_copy_done(nv_copy_done));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ********
    // helpers
    // ********
    // start pulses are counted so a write task may span two edges
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (nv_burn_start) n_burn = n_burn + 1;
        if (nv_copy_start) n_copy = n_copy + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask

    // strobe dropped a cycle before the next access, never re-raised in one step
    task wr(input [7:0] a, input [7:0] d);
        begin
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            tick(1);
            reg_wr = 1'b0;
            tick(1);
        end
    endtask

    task rd(input [7:0] a, input [7:0] exp);
        begin
            reg_addr = a;
            reg_rd = 1'b1;
            tick(1);
            reg_rd = 1'b0;
            chk(reg_rvalid, 1);
            chk(reg_rdata, exp);
            tick(1);
        end
    endtask

    task stop_test;
        begin
            $display("compares=%0d mismatches=%0d", compares, n_mismatch);
            if (n_mismatch == 0 && compares > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    // ********
    // main sequence
    // ********
    initial begin
        {reset, reg_wr, reg_rd, nv_burn_done, nv_copy_done} = 5'h10;
        {reg_addr, reg_wdata, freq_error_a, freq_error_b, nv_banks_used} = 0;
        // rows: offset, written byte, byte read back
        rows[0] = 24'h98A5A5;
        rows[1] = 24'h9AFF03;
        rows[2] = 24'h9B3C3C;
        rows[3] = 24'h9DFF0F;
        rows[4] = 24'h9E2121;
        rows[5] = 24'hA04343;
        rows[6] = 24'hA2FE02;
        rows[7] = 24'hA41212;
        rows[8] = 24'hA53434;
        rows[9] = 24'hA65656;
        rows[10] = 24'hA7FF1F;
        rows[11] = 24'hA98989;
        rows[12] = 24'hAA9A9A;
        rows[13] = 24'hAB7878;
        rows[14] = 24'hACEE0E;
        rows[15] = 24'hE5FF30;
        rows[16] = 24'hE61111;
        rows[17] = 24'hE72222;
        rows[18] = 24'hE83333;
        rows[19] = 24'hE9FF1F;
        rows[20] = 24'hE2FF03;
        rows[21] = 24'h99FF00;
        rows[22] = 24'hE35555;
        rows[23] = 24'hE40000;
        // limits in 0.1 ppm: 1, 3, 10, 30 ... 100000
        p = 1;
        for (i = 0; i < 11; i = i + 1) begin
            lim[i] = i[0] ? 3 * p : p;
            if (i[0]) p = p * 10;
        end
        tick(2);
        reset = 1'b0;
        tick(1);
        rd(8'h9E, 8'h00);
        for (i = 0; i < 24; i = i + 1) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        chk(acquire_extend_duration_a, 29'h1F332211);
        chk(n_burn, 0);
        chk(n_copy, 0);
        // threshold codes 0 to 11 on both loops, reserved code 11 last
        wr(8'h9A, 8'h03);
        wr(8'hA2, 8'h00);
        for (i = 0; i < 12; i = i + 1) begin
            wr(8'h9E, {2{i[3:0]}});
            wr(8'hA0, {2{i[3:0]}});
            freq_error_a = i < 11 ? lim[i] : 17'h1FFFF;
            freq_error_b = freq_error_a;
            tick(2);
            chk({lock_loss_b, lock_loss_a}, 0);
            if (i < 11) begin
                freq_error_a = lim[i] + 1;
                freq_error_b = freq_error_a;
                tick(1);
                chk({lock_loss_b, lock_loss_a}, 3);
                freq_error_a = 0;
                freq_error_b = 0;
                tick(1);
                chk({lock_loss_b, lock_loss_a}, 0);
            end
        end
        // loop b disabled, loop a delayed by one unit of 256 clocks
        wr(8'h9E, 8'h33);
        wr(8'hA0, 8'h33);
        wr(8'h9A, 8'h01);
        freq_error_a = 50;
        freq_error_b = 50;
        tick(2);
        chk({lock_loss_b, lock_loss_a}, 1);
        wr(8'h9A, 8'h03);
        wr(8'hA2, 8'h01);
        wr(8'hA4, 8'h01);
        wr(8'hA5, 8'h00);
        wr(8'hA6, 8'h00);
        wr(8'hA7, 8'h00);
        chk({lock_loss_b, lock_loss_a}, 3);
        freq_error_a = 0;
        freq_error_b = 0;
        tick(1);
        chk({lock_loss_b, lock_loss_a}, 1);
        tick(255);
        chk(lock_loss_a, 1);
        tick(1);
        chk(lock_loss_a, 0);
        // two burns, a key while busy, then no key once the status reads full
        for (i = 0; i < 3; i = i + 1) begin
            if (i < 2) wr(8'hE3, 8'hC7);
            if (i == 0) wr(8'hE3, 8'hC7);
            chk(n_burn, i < 2 ? i + 1 : 2);
            chk(nv_burn_busy, i < 2);
            nv_burn_done = i < 2;
            tick(1);
            nv_burn_done = 1'b0;
            tick(1);
            rd(8'hE2, i < 1 ? 8'h0F : 8'h3F);
        end
        // copy request and its self-clearing status bit
        wr(8'hE4, 8'h01);
        chk(n_copy, 1);
        rd(8'hE4, 8'h01);
        nv_copy_done = 1'b1;
        tick(1);
        nv_copy_done = 1'b0;
        tick(1);
        rd(8'hE4, 8'h00);
        // second reset picks up a new bank count
        nv_banks_used = 2'h1;
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        tick(1);
        chk({lock_loss_b, lock_loss_a, nv_burn_busy}, 0);
        rd(8'hE2, 8'h0F);
        rd(8'h9A, 8'h00);
        stop_test;
    end
endmodule
